// [shared/fcsm_consts.svh]
// Constants for the flash command sequencer host controller
`ifndef FCSM_CONSTS_SVH
`define FCSM_CONSTS_SVH
// Register offsets (byte addresses)
`define FCSM_REG_CTRL    4'h0
`define FCSM_REG_ADDR    4'h4
`define FCSM_REG_WDATA   4'h8
`define FCSM_REG_STATUS  4'hC
// Control fields
`define FCSM_CMD_LSB     0
`define FCSM_CMD_MSB     2
`define FCSM_CTRL_START  3
`define FCSM_CTRL_BYTE   4
// Command codes
`define FCSM_OP_READ     3'h0
`define FCSM_OP_RESET    3'h1
`define FCSM_OP_AUTOSEL  3'h2
`define FCSM_OP_PROGRAM  3'h3
`define FCSM_OP_WRITE    3'h4
// Unlock and command patterns, configurable
`define FCSM_UNLOCK1_ADDR 20'h0_0555
`define FCSM_UNLOCK1_DATA 16'h00AA
`define FCSM_UNLOCK2_ADDR 20'h0_02AA
`define FCSM_UNLOCK2_DATA 16'h0055
`define FCSM_RESET_DATA   16'h00F0
`define FCSM_AUTOSEL_DATA 16'h0090
`define FCSM_PROGRAM_DATA 16'h00A0
// Strobe timing: 20 ns clock, pulses far above the 5 ns glitch filter
`define FCSM_CLK_NS      20
`define FCSM_GLITCH_NS   5
`define FCSM_PHASE_CYC   2
`define FCSM_SLOT_MSB    2
`define FCSM_BUS_RESP_OK 2'b00
`define FCSM_BUS_RESP_ERR 2'b10
`endif

// [shared/fcsm_pkg.sv]
// Types for the flash command sequencer host controller
package fcsm_pkg;
	typedef enum logic [2:0] {
		FCSM_IDLE,
		FCSM_SETUP,
		FCSM_STROBE,
		FCSM_HOLD,
		FCSM_RSETUP,
		FCSM_RSAMPLE,
		FCSM_DONE
	} fcsm_state_type;
endpackage : fcsm_pkg

// [src/fcsm_host.sv]
// Host controller that drives the flash command state machine over its strobes
// Notes on behaviour
// [RULE1] Protected sectors refuse program and erase
// [RULE2] High reset voltage temporarily unprotects sectors
// [RULE3] Glitches under 5 ns start nothing
// [RULE4] Write needs chip select, strobe low, enable high
// [RULE5] Power-up write held low is ignored
// [RULE6] Bad sequence returns device to array read
// [RULE7] Address on later fall, data earlier rise
// [RULE8] Embedded operation ends in array read
// [RULE9] Suspended sector reads return status data
// [RULE10] Host resets after timeout flag or autoselect
// [RULE11] Reset aborts erase sequence before erasure
// [RULE12] Reset aborts program sequence before programming
// [RULE13] Only reset leaves autoselect mode
// [RULE14] Reset recovers after timing-exceeded flag
// [RULE15] Autoselect: two unlocks then command, many reads
// [RULE16] Autoselect reads give maker and device codes
// [RULE17] Sector address read gives protection bit
// [RULE18] Program is four writes, width by byte pin
// [RULE19] Running program ignores commands, reset stops it
// [RULE20] Progress on status bits and ready/busy
// [RULE21] Program never turns zero into one
// [RULE22] Low supply blocks writes and resets device
// [RULE23] Reset pin low ends operations, floats outputs
// [RULE24] Unlock and command patterns are configurable constants
`timescale 1ns/1ps
`include "fcsm_consts.svh"

module fcsm_host #(
	parameter int ADDR_W = 20,
	parameter int DATA_W = 16
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [3:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [3:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Flash pins
	output logic [ADDR_W-1:0]      flash_addr,
	input  wire logic [DATA_W-1:0] flash_dq_in,
	output logic [DATA_W-1:0]      flash_dq_out,
	output logic                   flash_dq_oe,
	output logic                   flash_chip_sel_n,
	output logic                   flash_out_en_n,
	output logic                   flash_write_n,
	output logic                   flash_byte_n,
	output logic                   flash_reset_n,
	input  wire logic              ready_busy_n
);

	//------------------------------------------------------------
	// Register file
	//------------------------------------------------------------
	logic [2:0]        cmd, next_cmd;
	logic              byte_mode, next_byte_mode;
	logic [ADDR_W-1:0] op_addr, next_op_addr;
	logic [DATA_W-1:0] op_data, next_op_data;
	logic [DATA_W-1:0] rd_data, next_rd_data;
	logic              aw_hold, next_aw_hold, w_hold, next_w_hold;
	logic [3:0]        aw_addr, next_aw_addr;
	logic [31:0]       w_data, next_w_data;
	logic [3:0]        w_strb, next_w_strb;
	logic              bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0]        bresp, next_bresp, rresp, next_rresp;
	logic [31:0]       rdata, next_rdata;
	logic              start_pulse;

	// Sequencer state
	fcsm_pkg::fcsm_state_type state, next_state;
	logic [`FCSM_SLOT_MSB:0]  slot, next_slot;
	logic [`FCSM_SLOT_MSB:0]  nslots;
	logic [1:0]               tcnt, next_tcnt;
	logic [ADDR_W-1:0]        cyc_addr;
	logic [DATA_W-1:0]        cyc_data;
	logic                     cyc_read;
	logic                     busy;

	assign busy = (state != fcsm_pkg::FCSM_IDLE);

	function automatic logic sel_ok(input logic [3:0] a);
		sel_ok = (a == `FCSM_REG_CTRL) || (a == `FCSM_REG_ADDR)
			|| (a == `FCSM_REG_WDATA) || (a == `FCSM_REG_STATUS);
	endfunction : sel_ok

	assign s_axi_awready = !aw_hold && !bvalid;
	assign s_axi_wready  = !w_hold && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid  = bvalid;
	assign s_axi_bresp   = bresp;
	assign s_axi_rvalid  = rvalid;
	assign s_axi_rresp   = rresp;
	assign s_axi_rdata   = rdata;

	always_comb
	begin
		logic have_aw;
		logic have_w;
		logic [3:0] a;
		logic [31:0] d;
		have_aw = aw_hold || (s_axi_awvalid && s_axi_awready);
		have_w  = w_hold || (s_axi_wvalid && s_axi_wready);
		a = aw_hold ? aw_addr : s_axi_awaddr;
		d = w_hold ? w_data : s_axi_wdata;
		next_aw_hold = aw_hold;
		next_w_hold = w_hold;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_hold ? w_strb : s_axi_wstrb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_cmd = cmd;
		next_byte_mode = byte_mode;
		next_op_addr = op_addr;
		next_op_data = op_data;
		start_pulse = 1'b0;
		if (bvalid && s_axi_bready)
			next_bvalid = 1'b0;
		if (have_aw && have_w)
		begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = sel_ok(a) ? `FCSM_BUS_RESP_OK : `FCSM_BUS_RESP_ERR;
			// Writes while busy are dropped so a sequence is never torn apart
			if (a == `FCSM_REG_CTRL && next_w_strb[0] && !busy)
			begin
				next_cmd = d[`FCSM_CMD_MSB:`FCSM_CMD_LSB];
				next_byte_mode = d[`FCSM_CTRL_BYTE];
				start_pulse = d[`FCSM_CTRL_START];
			end
			else if (a == `FCSM_REG_ADDR && !busy)
				next_op_addr = d[ADDR_W-1:0];
			else if (a == `FCSM_REG_WDATA && !busy)
				next_op_data = d[DATA_W-1:0];
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				next_aw_hold = 1'b1;
				next_aw_addr = s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				next_w_hold = 1'b1;
				next_w_data = s_axi_wdata;
			end
		end
	end

	always_comb
	begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = sel_ok(s_axi_araddr) ? `FCSM_BUS_RESP_OK : `FCSM_BUS_RESP_ERR;
			if (s_axi_araddr == `FCSM_REG_CTRL)
				next_rdata = {27'h000_0000, byte_mode, 1'b0, cmd};
			else if (s_axi_araddr == `FCSM_REG_ADDR)
				next_rdata = 32'(op_addr);
			else if (s_axi_araddr == `FCSM_REG_WDATA)
				next_rdata = 32'(op_data);
			else if (s_axi_araddr == `FCSM_REG_STATUS)
				// Busy, device ready/busy and last data read (status bits included)
				next_rdata = {14'h0000, ready_busy_n, busy, rd_data}; // [RULE20]
			else
				next_rdata = 32'h0000_0000;
		end
	end

	//------------------------------------------------------------
	// Bus cycle sequencer
	//------------------------------------------------------------
	// Each slot is one write or read cycle on the flash pins
	always_comb
	begin
		nslots = 3'd1;
		cyc_read = 1'b0;
		cyc_addr = op_addr;
		cyc_data = op_data;
		case (cmd)
			`FCSM_OP_READ:
			begin
				cyc_read = 1'b1;
			end
			`FCSM_OP_RESET:
			begin
				cyc_data = `FCSM_RESET_DATA; // [RULE10]
			end
			`FCSM_OP_AUTOSEL, `FCSM_OP_PROGRAM:
			begin
				nslots = (cmd == `FCSM_OP_PROGRAM) ? 3'd4 : 3'd3; // [RULE18] [RULE15]
				if (slot == 3'd0)
				begin
					cyc_addr = ADDR_W'(`FCSM_UNLOCK1_ADDR); // [RULE24]
					cyc_data = `FCSM_UNLOCK1_DATA;
				end
				else if (slot == 3'd1)
				begin
					cyc_addr = ADDR_W'(`FCSM_UNLOCK2_ADDR);
					cyc_data = `FCSM_UNLOCK2_DATA;
				end
				else if (slot == 3'd2)
				begin
					cyc_addr = ADDR_W'(`FCSM_UNLOCK1_ADDR);
					cyc_data = (cmd == `FCSM_OP_PROGRAM) ? `FCSM_PROGRAM_DATA
						: `FCSM_AUTOSEL_DATA;
				end
			end
			default:
			begin
				nslots = 3'd1;
			end
		endcase
	end

	always_comb
	begin
		next_state = state;
		next_slot = slot;
		next_tcnt = tcnt;
		next_rd_data = rd_data;
		case (state)
			fcsm_pkg::FCSM_IDLE:
				if (start_pulse)
				begin
					next_slot = 3'd0;
					next_tcnt = 2'd0;
					next_state = fcsm_pkg::FCSM_SETUP;
				end
			fcsm_pkg::FCSM_SETUP:
			begin
				next_tcnt = 2'd0;
				next_state = cyc_read ? fcsm_pkg::FCSM_RSETUP : fcsm_pkg::FCSM_STROBE;
			end
			// Strobe low for two clocks, well above the glitch filter
			fcsm_pkg::FCSM_STROBE:
				if (tcnt == 2'(`FCSM_PHASE_CYC - 1)) // [RULE3]
				begin
					next_tcnt = 2'd0;
					next_state = fcsm_pkg::FCSM_HOLD;
				end
				else
					next_tcnt = tcnt + 2'd1;
			fcsm_pkg::FCSM_HOLD:
				if (slot == nslots - 3'd1)
					next_state = fcsm_pkg::FCSM_DONE;
				else
				begin
					next_slot = slot + 3'd1;
					next_state = fcsm_pkg::FCSM_SETUP;
				end
			fcsm_pkg::FCSM_RSETUP:
				if (tcnt == 2'(`FCSM_PHASE_CYC - 1))
					next_state = fcsm_pkg::FCSM_RSAMPLE;
				else
					next_tcnt = tcnt + 2'd1;
			fcsm_pkg::FCSM_RSAMPLE:
			begin
				next_rd_data = flash_dq_in; // [RULE9] [RULE16] [RULE17]
				next_state = fcsm_pkg::FCSM_DONE;
			end
			fcsm_pkg::FCSM_DONE:
				next_state = fcsm_pkg::FCSM_IDLE;
			default:
				next_state = fcsm_pkg::FCSM_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= fcsm_pkg::FCSM_IDLE;
			slot <= 3'd0;
			tcnt <= 2'd0;
			rd_data <= '0;
			cmd <= `FCSM_OP_READ;
			byte_mode <= 1'b0;
			op_addr <= '0;
			op_data <= '0;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `FCSM_BUS_RESP_OK;
			rvalid <= 1'b0;
			rresp <= `FCSM_BUS_RESP_OK;
			rdata <= 32'h0000_0000;
		end
		else
		begin
			state <= next_state;
			slot <= next_slot;
			tcnt <= next_tcnt;
			rd_data <= next_rd_data;
			cmd <= next_cmd;
			byte_mode <= next_byte_mode;
			op_addr <= next_op_addr;
			op_data <= next_op_data;
			aw_hold <= next_aw_hold;
			w_hold <= next_w_hold;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end

	//------------------------------------------------------------
	// Pin drive, all from flip-flops
	//------------------------------------------------------------
	// Output enable stays high on writes so the write is never inhibited
	// Pins follow the state one cycle late, so address and data settle a full
	// cycle before the strobe falls instead of moving on the same edge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			flash_addr <= '0;
			flash_dq_out <= '0;
			flash_dq_oe <= 1'b0;
			flash_chip_sel_n <= 1'b1;
			flash_out_en_n <= 1'b1;
			flash_write_n <= 1'b1;
			flash_byte_n <= 1'b1;
			flash_reset_n <= 1'b0; // [RULE23]
		end
		else
		begin
			flash_reset_n <= 1'b1;
			flash_addr <= cyc_addr;
			flash_dq_out <= cyc_data;
			flash_byte_n <= !byte_mode; // [RULE18]
			flash_dq_oe <= (state == fcsm_pkg::FCSM_STROBE)
				|| (state == fcsm_pkg::FCSM_HOLD);
			flash_chip_sel_n <= !((state == fcsm_pkg::FCSM_STROBE)
				|| (state == fcsm_pkg::FCSM_RSETUP)
				|| (state == fcsm_pkg::FCSM_RSAMPLE));
			flash_write_n <= !(state == fcsm_pkg::FCSM_STROBE); // [RULE4]
			flash_out_en_n <= !((state == fcsm_pkg::FCSM_RSETUP)
				|| (state == fcsm_pkg::FCSM_RSAMPLE));
		end
	end

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	AST_WRITE_OE_HIGH: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
		!flash_write_n |-> (flash_out_en_n && !flash_chip_sel_n))
		else $error("write strobe low while output enable low");
	AST_WRITE_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
		$fell(flash_write_n) |-> !flash_write_n [*2] ##1 flash_write_n)
		else $error("write strobe pulse not two cycles");
	AST_DATA_DRIVEN: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
		$rose(flash_write_n) |-> flash_dq_oe)
		else $error("data not held at strobe rise");
	AST_RESET_WORD: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
		(!flash_write_n && cmd == `FCSM_OP_RESET) |-> flash_dq_out == `FCSM_RESET_DATA)
		else $error("reset command data wrong");
	AST_UNLOCK_FIRST: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE24]
		(state == fcsm_pkg::FCSM_STROBE && slot == 3'd0 && cmd == `FCSM_OP_PROGRAM)
		|-> flash_addr == ADDR_W'(`FCSM_UNLOCK1_ADDR))
		else $error("first unlock address wrong");
	AST_PROG_LEN: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE18]
		(state == fcsm_pkg::FCSM_DONE && cmd == `FCSM_OP_PROGRAM) |-> $past(slot) == 3'd3)
		else $error("program sequence not four cycles");
	AST_NO_READ_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE23]
		!flash_out_en_n |-> !flash_dq_oe)
		else $error("bus driven during read");
	AST_DONE_IDLE: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE15]
		state == fcsm_pkg::FCSM_DONE |=> state == fcsm_pkg::FCSM_IDLE)
		else $error("sequencer stuck after done");
	COV_PROGRAM: cover property (@(posedge aclk) disable iff (!aresetn)
		state == fcsm_pkg::FCSM_DONE && cmd == `FCSM_OP_PROGRAM);
	COV_AUTOSEL: cover property (@(posedge aclk) disable iff (!aresetn)
		state == fcsm_pkg::FCSM_DONE && cmd == `FCSM_OP_AUTOSEL);
	COV_READ: cover property (@(posedge aclk) disable iff (!aresetn)
		state == fcsm_pkg::FCSM_RSAMPLE);

endmodule : fcsm_host

// [verification/fcsm_flash_model.sv]
// Behavioural flash device answering the host controller's strobes
`timescale 1ns/1ps
`include "fcsm_consts.svh"
module fcsm_flash_model #(
	parameter logic [15:0] MAKER_CODE  = 16'h005A, // Arbitrary value
	parameter logic [15:0] DEVICE_CODE = 16'h00C3, // Arbitrary value
	parameter int          BUSY_NS     = 300
) (
	// Host strobes and buses
	input  wire logic [19:0] flash_addr,
	input  wire logic [15:0] flash_dq_out,
	input  wire logic        flash_dq_oe,
	input  wire logic        flash_chip_sel_n,
	input  wire logic        flash_out_en_n,
	input  wire logic        flash_write_n,
	input  wire logic        flash_byte_n,
	input  wire logic        flash_reset_n,
	// Device answers
	output logic [15:0]      flash_dq_in,
	output logic             ready_busy_n
);
	// ----
	// Command decoder
	// ----
	logic [15:0] mem [256];
	logic [15:0] val;
	logic [15:0] last;
	logic [19:0] la;
	logic        busy;
	logic        auto;
	int          step;
	realtime     t_fall;
	wire wr = !flash_chip_sel_n && !flash_write_n && flash_out_en_n;
	wire rd = !flash_chip_sel_n && !flash_out_en_n && flash_reset_n;
	function automatic logic [15:0] auto_code(input logic [19:0] a, input logic bm);
		if (a[7:0] == 8'h00) return MAKER_CODE;
		if (a[7:0] == (bm ? 8'h02 : 8'h01)) return DEVICE_CODE;
		if (a[7:0] == (bm ? 8'h04 : 8'h02)) return {15'h0000, a[19]};
		return 16'h0000;
	endfunction : auto_code
	initial
	begin
		foreach (mem[i]) mem[i] = 16'hFFFF;
		{busy, auto, step, last} = '0;
		// An end of write with no start seen since power-up is never a write
		t_fall = 1.0e9;
	end
	// Write active starts at the later falling strobe: address taken here
	always @(posedge wr)
	begin
		la = flash_addr;
		t_fall = $realtime;
	end
	// Write active ends at the earlier rising strobe: data taken here
	always @(negedge wr or negedge flash_reset_n)
	begin
		if (!flash_reset_n)
			{busy, auto, step} = '0;
		else if ($realtime - t_fall >= 5.0 && flash_dq_oe && !busy)
		begin
			if (step != 3 && flash_dq_out == `FCSM_RESET_DATA)
				{auto, step} = '0;
			else if (auto)
				step = 0;
			else if (step == 3)
			begin
				if (!la[19])
					mem[la[7:0]] = mem[la[7:0]] & flash_dq_out;
				step = 0;
				busy = 1'b1;
				busy <= #(BUSY_NS) 1'b0;
			end
			else if (step < 2)
				step = (la == (step ? `FCSM_UNLOCK2_ADDR : `FCSM_UNLOCK1_ADDR) &&
					flash_dq_out == (step ? `FCSM_UNLOCK2_DATA : `FCSM_UNLOCK1_DATA))
					? step + 1 : 0;
			else
			begin
				auto = la == `FCSM_UNLOCK1_ADDR && flash_dq_out == `FCSM_AUTOSEL_DATA;
				step = (la == `FCSM_UNLOCK1_ADDR && flash_dq_out == `FCSM_PROGRAM_DATA)
					? 3 : 0;
			end
			t_fall = 1.0e9;
		end
	end
	always @*
	begin
		if (busy)
			val = {8'h00, ~mem[la[7:0]][7], 7'h00};
		else if (auto)
			val = auto_code(flash_addr, !flash_byte_n);
		else
			val = mem[flash_addr[7:0]];
		if (rd)
			last = val;
	end
	// A released bus shows the inverse of its last value, never a stale copy
	assign flash_dq_in  = rd ? val : ~last;
	assign ready_busy_n = !busy;
endmodule : fcsm_flash_model

// [verification/testbench.sv]
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "fcsm_consts.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("MISMATCH at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
	// ----
	// Signals and instances
	// ----
	localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value
	localparam logic [15:0] DEV   = 16'h00C3; // Arbitrary value
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, flash_dq_oe, flash_chip_sel_n, flash_out_en_n, flash_write_n;
	logic        flash_byte_n, flash_reset_n, ready_busy_n;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rresp, wresp;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, st;
	logic [19:0] flash_addr;
	logic [15:0] flash_dq_in, flash_dq_out;
	int          n_mismatch, comparisons;
	logic [19:0] aa [4] = '{20'h0_0000, 20'h0_0001, 20'h8_0002, 20'h0_0002};
	logic [15:0] ae [4] = '{MAKER, DEV, 16'h0001, 16'h0000};
	fcsm_host i_dut (.*);
	fcsm_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEV)) i_flash (.*);
	initial aclk = 1'b0;
	always #10 aclk = ~aclk;
	// Output enable is never low while chip select and the write strobe are low
	always @(negedge aclk)
		if (aresetn && !flash_write_n && !flash_chip_sel_n)
			`CHK(flash_out_en_n, 1'b1)
	// ----
	// Bus tasks
	// ----
	task automatic complete_run();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	task automatic give_up();
		n_mismatch++;
		$display("MISMATCH at %0t: no answer", $time);
		complete_run();
	endtask : give_up
	// Handshakes are judged at the falling edge, where nothing moves
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		logic aw, w, b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		b = 1'b0;
		for (int n = 0; n < 100 && !b; n++)
		begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid && s_axi_bready;
			wresp = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
		if (!b) give_up();
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a);
		logic ar, r;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		r = 1'b0;
		for (int n = 0; n < 100 && !r; n++)
		begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid && s_axi_rready;
			rd = s_axi_rdata;
			rresp = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
		if (!r) give_up();
	endtask : axi_read
	// One flash operation, then poll until idle and the device is ready
	task automatic op(input logic [2:0] c, input logic bm, input logic [19:0] a,
		input logic [15:0] d);
		axi_write(`FCSM_REG_ADDR, {12'h000, a});
		axi_write(`FCSM_REG_WDATA, {16'h0000, d});
		axi_write(`FCSM_REG_CTRL, {27'h000_0000, bm, 1'b1, c});
		st = 32'h0001_0000;
		for (int n = 0; n < 50 && st[17:16] !== 2'b10; n++)
		begin
			axi_read(`FCSM_REG_STATUS);
			st = rd;
		end
		if (st[17:16] !== 2'b10) give_up();
	endtask : op
	// ----
	// Main sequence
	// ----
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{n_mismatch, comparisons} = '0;
		repeat (16) @(posedge aclk);
		`CHK(flash_reset_n, 1'b0)
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHK(flash_reset_n, 1'b1)
		axi_read(4'h2);
		`CHK(rresp, `FCSM_BUS_RESP_ERR)
		axi_write(4'h2, 32'h0000_0000);
		`CHK(wresp, `FCSM_BUS_RESP_ERR)
		op(`FCSM_OP_PROGRAM, 1'b0, 20'h0_0010, 16'h1234);
		`CHK(wresp, `FCSM_BUS_RESP_OK)
		op(`FCSM_OP_READ, 1'b0, 20'h0_0010, 16'h0000);
		`CHK(st[15:0], 16'h1234)
		op(`FCSM_OP_PROGRAM, 1'b0, 20'h0_0010, 16'hFF00);
		op(`FCSM_OP_READ, 1'b0, 20'h0_0010, 16'h0000);
		`CHK(st[15:0], 16'h1200)
		op(`FCSM_OP_PROGRAM, 1'b0, 20'h8_0020, 16'h0000);
		op(`FCSM_OP_READ, 1'b0, 20'h8_0020, 16'h0000);
		`CHK(st[15:0], 16'hFFFF)
		op(`FCSM_OP_AUTOSEL, 1'b0, 20'h0_0000, 16'h0000);
		foreach (aa[i])
		begin
			op(`FCSM_OP_READ, 1'b0, aa[i], 16'h0000);
			`CHK(st[15:0], ae[i])
		end
		op(`FCSM_OP_RESET, 1'b0, 20'h0_0000, 16'h0000);
		op(`FCSM_OP_READ, 1'b0, 20'h0_0010, 16'h0000);
		`CHK(st[15:0], 16'h1200)
		op(`FCSM_OP_AUTOSEL, 1'b1, 20'h0_0000, 16'h0000);
		`CHK(flash_byte_n, 1'b0)
		op(`FCSM_OP_READ, 1'b1, 20'h0_0002, 16'h0000);
		`CHK(st[15:0], DEV)
		op(`FCSM_OP_READ, 1'b1, 20'h8_0004, 16'h0000);
		`CHK(st[15:0], 16'h0001)
		op(`FCSM_OP_RESET, 1'b0, 20'h0_0000, 16'h0000);
		op(`FCSM_OP_WRITE, 1'b0, `FCSM_UNLOCK1_ADDR, `FCSM_UNLOCK1_DATA);
		op(`FCSM_OP_WRITE, 1'b0, `FCSM_UNLOCK2_ADDR, 16'h0077);
		op(`FCSM_OP_WRITE, 1'b0, `FCSM_UNLOCK1_ADDR, `FCSM_PROGRAM_DATA);
		op(`FCSM_OP_WRITE, 1'b0, 20'h0_0030, 16'h0000);
		op(`FCSM_OP_READ, 1'b0, 20'h0_0030, 16'h0000);
		`CHK(st[15:0], 16'hFFFF)
		op(`FCSM_OP_WRITE, 1'b0, `FCSM_UNLOCK1_ADDR, `FCSM_UNLOCK1_DATA);
		op(`FCSM_OP_WRITE, 1'b0, `FCSM_UNLOCK2_ADDR, `FCSM_UNLOCK2_DATA);
		op(`FCSM_OP_RESET, 1'b0, 20'h0_0000, 16'h0000);
		op(`FCSM_OP_WRITE, 1'b0, `FCSM_UNLOCK1_ADDR, `FCSM_PROGRAM_DATA);
		op(`FCSM_OP_WRITE, 1'b0, 20'h0_0040, 16'h0000);
		op(`FCSM_OP_READ, 1'b0, 20'h0_0040, 16'h0000);
		`CHK(st[15:0], 16'hFFFF)
		complete_run();
	end
endmodule : testbench
